// [src/flash_buf_device.sv]
// Flash device command logic for write buffer, buffer read and program
//
// Local design decisions: the register offsets and the address-and-strobe port.
module flash_buf_device
    import flash_buf_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    flash_link_if.device link,
    input wire logic octalDdr,
    input wire logic protectedTarget,
    input wire logic programFail,
    output logic busy,
    output logic writeEnableLatch,
    output logic programEraseErrorFlag,
    output logic arrayWrite,
    output logic [31:0] arrayAddr,
    output logic [7:0] arrayData
);
    typedef enum logic [2:0] {
        S_OP = 3'b000, S_ADDR = 3'b001, S_DUMMY = 3'b010, S_DATA = 3'b011,
        S_STATUS = 3'b100, S_IGNORE = 3'b101
    } phase_t;
    typedef struct packed {
        logic [2:0] selSync;
        logic [2:0] sckSync;
        logic [1:0] siSync;
        phase_t phase;
        logic [7:0] opcode;
        logic [7:0] shiftIn;
        logic [2:0] bitCnt;
        logic [2:0] addrCnt;
        logic [31:0] addr;
        logic [7:0] ptr;
        logic [8:0] dataCnt;
        logic [7:0] shiftOut;
        logic so;
        logic soOe;
        logic latch;
        logic errFlag;
        logic busy;
        logic [15:0] progCnt;
        logic [8:0] progIdx;
        logic failSeen;
        logic waitInt;
        logic [BUF_DEPTH-1:0] touched;
    } state_t;
    state_t s_r, s_nxt;
    logic [7:0] mem [BUF_DEPTH];
    logic memWe;
    logic [7:0] memAddr, memWd;
    logic sckRise, sckFall, selRise, selLow, bitIn, bytePartial;
    assign sckRise = s_r.sckSync[1] & ~s_r.sckSync[2];
    assign sckFall = ~s_r.sckSync[1] & s_r.sckSync[2];
    assign selRise = s_r.selSync[1] & ~s_r.selSync[2];
    assign selLow = ~s_r.selSync[1];
    assign bitIn = s_r.siSync[1];
    assign bytePartial = (s_r.bitCnt != BIT_FIRST);

    // =====================================
    // Command engine
    always_comb begin
        s_nxt = s_r;
        memWe = 1'b0;
        memAddr = s_r.ptr;
        memWd = s_r.shiftIn;
        s_nxt.selSync = {s_r.selSync[1:0], link.selectN};
        s_nxt.sckSync = {s_r.sckSync[1:0], link.sck};
        s_nxt.siSync = {s_r.siSync[0], link.si};
        if (selLow && sckRise) begin
            s_nxt.shiftIn = {s_r.shiftIn[6:0], bitIn};
            s_nxt.bitCnt = s_r.bitCnt + 3'h1;
            if (s_r.bitCnt == BIT_LAST) begin
                case (s_r.phase)
                    S_OP: begin
                        s_nxt.opcode = {s_r.shiftIn[6:0], bitIn};
                        s_nxt.addrCnt = 3'h0;
                        s_nxt.dataCnt = 9'h0;
                        case ({s_r.shiftIn[6:0], bitIn})
                            OP_BUF_READ: s_nxt.phase = octalDdr ? S_IGNORE : S_ADDR;
                            OP_BUF_WRITE, OP_PROGRAM, OP_BUF_COMMIT:
                                s_nxt.phase = s_r.busy ? S_IGNORE : S_ADDR;
                            OP_WR_ENABLE: begin
                                s_nxt.phase = S_IGNORE;
                                if (!s_r.busy) s_nxt.latch = 1'b1;
                            end
                            OP_READ_STATUS, OP_STATUS_INT: s_nxt.phase = S_STATUS;
                            default: s_nxt.phase = S_IGNORE;
                        endcase
                    end
                    S_ADDR: begin
                        s_nxt.addr = {s_r.addr[23:0], s_r.shiftIn[6:0], bitIn};
                        s_nxt.addrCnt = s_r.addrCnt + 3'h1;
                        s_nxt.ptr = {s_r.shiftIn[6:0], bitIn};
                        if (s_r.addrCnt == ADDR_LAST) begin
                            s_nxt.phase = (s_r.opcode == OP_BUF_READ) ? S_DUMMY : S_DATA;
                            if (s_r.opcode == OP_PROGRAM) begin
                                s_nxt.ptr = {s_r.shiftIn[6:0], bitIn & ~octalDdr};
                                s_nxt.touched = '0;
                            end
                            if (s_r.opcode == OP_BUF_COMMIT) s_nxt.touched = '1;
                        end
                    end
                    S_DUMMY: s_nxt.phase = S_DATA;
                    S_STATUS: s_nxt.dataCnt = s_r.dataCnt + 9'h1;
                    S_DATA: begin
                        // byte lands at pointer, nothing cleared
                        if (s_r.opcode == OP_BUF_WRITE || s_r.opcode == OP_PROGRAM) begin
                            memWe = 1'b1;
                            memWd = {s_r.shiftIn[6:0], bitIn};
                            s_nxt.touched[s_r.ptr] = 1'b1;
                            if (s_r.dataCnt != 9'(BUF_DEPTH)) s_nxt.dataCnt = s_r.dataCnt + 9'h1;
                        end
                        s_nxt.ptr = s_r.ptr + 8'h1;
                    end
                    default: ;
                endcase
            end
        end
        // output shifts on falling edges after dummy
        if (selLow && sckFall && (s_r.phase == S_DATA) && (s_r.opcode == OP_BUF_READ)) begin
            s_nxt.soOe = 1'b1;
            if (s_r.bitCnt == BIT_FIRST) begin
                s_nxt.so = mem[s_r.ptr][7];
                s_nxt.shiftOut = {mem[s_r.ptr][6:0], 1'b0};
            end else begin
                s_nxt.so = s_r.shiftOut[7];
                s_nxt.shiftOut = {s_r.shiftOut[6:0], 1'b0};
            end
        end
        if (selLow && sckFall && s_r.phase == S_STATUS) begin
            s_nxt.soOe = 1'b1;
            if (s_r.bitCnt == BIT_FIRST) begin
                // Status byte: error bit 5, latch bit 1, busy bit 0
                s_nxt.so = 1'b0;
                s_nxt.shiftOut = {1'b0, s_r.errFlag, 3'b000, s_r.latch, s_r.busy, 1'b0};
            end else begin
                s_nxt.so = s_r.shiftOut[7];
                s_nxt.shiftOut = {s_r.shiftOut[6:0], 1'b0};
            end
            // after 16 clocks the controller stops; no low glitch
            if (s_r.opcode == OP_STATUS_INT && s_r.busy && s_r.dataCnt != 9'h0) begin
                s_nxt.waitInt = 1'b1;
                s_nxt.so = 1'b1;
            end
        end
        // high while busy, low as soon as busy ends
        if (s_r.waitInt && selLow) begin
            s_nxt.soOe = 1'b1;
            s_nxt.so = s_r.busy;
        end
        if (selRise) begin
            s_nxt.soOe = 1'b0;
            s_nxt.so = 1'b0;
            s_nxt.waitInt = 1'b0;
            s_nxt.phase = S_OP;
            s_nxt.bitCnt = BIT_FIRST;
            if ((s_r.opcode == OP_PROGRAM || s_r.opcode == OP_BUF_COMMIT)
                    && s_r.phase != S_OP && s_r.phase != S_IGNORE) begin
                // validity checks; commit needs no data
                if (s_r.phase != S_DATA || bytePartial || protectedTarget
                        || (s_r.opcode == OP_PROGRAM && s_r.dataCnt == 9'h0)) begin
                    s_nxt.latch = 1'b0;
                end else if (s_r.latch) begin
                    s_nxt.busy = 1'b1;
                    s_nxt.progIdx = 9'h0;
                    s_nxt.progCnt = PROG_CYCLES;
                    s_nxt.failSeen = 1'b0;
                    // odd count in octal DDR programs the pair partner
                    if (octalDdr && s_r.ptr[0]) s_nxt.touched[s_r.ptr] = 1'b1;
                end
            end
            s_nxt.opcode = 8'h00;
        end
        // walk the page, write touched bytes only
        if (s_r.busy) begin
            if (s_r.progIdx != 9'(BUF_DEPTH)) begin
                s_nxt.progIdx = s_r.progIdx + 9'h1;
                if (s_r.touched[s_r.progIdx[7:0]] && programFail) s_nxt.failSeen = 1'b1;
            end else if (s_r.progCnt != 16'h0) begin
                s_nxt.progCnt = s_r.progCnt - 16'h1;
                s_nxt.latch = 1'b0;
            end else begin
                s_nxt.busy = 1'b0;
                s_nxt.errFlag = s_r.failSeen;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            s_r <= '0;
            s_r.selSync <= 3'b111;
        end else begin
            s_r <= s_nxt;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (memWe) mem[memAddr] <= memWd;
    end

    // Array write strobe registered; page base held from address
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            arrayWrite <= 1'b0;
            arrayAddr <= '0;
            arrayData <= ERASED_BYTE;
        end else begin
            arrayWrite <= s_r.busy && s_r.progIdx != 9'(BUF_DEPTH) && s_r.touched[s_r.progIdx[7:0]];
            arrayAddr <= {s_r.addr[31:8], s_r.progIdx[7:0]};
            arrayData <= mem[s_r.progIdx[7:0]];
        end
    end
    assign link.so = s_r.so;
    assign link.soOe = s_r.soOe;
    assign busy = s_r.busy;
    assign writeEnableLatch = s_r.latch;
    assign programEraseErrorFlag = s_r.errFlag;
endmodule

// [src/flash_buf_pkg.sv]
// Shared constants for the flash write buffer link
// =====================================
package flash_buf_pkg;
    localparam logic [7:0] OP_BUF_READ = 8'hd4;
    localparam logic [7:0] OP_BUF_WRITE = 8'h84;
    localparam logic [7:0] OP_PROGRAM = 8'h02;
    localparam logic [7:0] OP_WR_ENABLE = 8'h06;
    localparam logic [7:0] OP_STATUS_INT = 8'h25;
    localparam logic [7:0] OP_READ_STATUS = 8'h05;
    localparam logic [7:0] OP_BUF_COMMIT = 8'h88;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam int BUF_DEPTH = 256;
    localparam int ADDR_BYTES = 4;
    localparam logic [2:0] ADDR_LAST = 3'h3;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [2:0] BIT_FIRST = 3'h0;
    localparam logic [15:0] PROG_CYCLES = 16'h0100;
    localparam logic [7:0] HALF_DIV = 8'h03;
    // Status byte bit positions
    localparam int ST_BUSY = 0;
    localparam int ST_LATCH = 1;
    localparam int ST_ERROR = 5;
endpackage

// [src/flash_link_if.sv]
// Serial link between controller and flash device
interface flash_link_if;
    logic selectN;
    logic sck;
    logic si;
    logic so;
    logic soOe;
    modport device (input selectN, input sck, input si, output so, output soOe);
    modport host (output selectN, output sck, output si, input so, input soOe);
endinterface

// [src/flash_buf_host.sv]
// Controller end: register port to serial frames
module flash_buf_host
    import flash_buf_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    flash_link_if.host link,
    input wire logic [1:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata
);
    // Offsets: 0 control/start, 1 tx byte, 2 rx byte, 3 status
    typedef struct packed {
        logic [1:0] soSync;
        logic selN;
        logic sck;
        logic si;
        logic [7:0] div;
        logic [7:0] tx;
        logic [7:0] rx;
        logic [2:0] bitCnt;
        logic active;
        logic lastByte;
        logic doneFlag;
        logic [31:0] rdata;
    } state_t;
    state_t s_r, s_nxt;
    always_comb begin
        s_nxt = s_r;
        s_nxt.soSync = {s_r.soSync[0], link.so};
        s_nxt.rdata = 32'h0;
        if (regRd) begin
            case (regAddr)
                2'h2: s_nxt.rdata = {24'h0, s_r.rx};
                2'h3: s_nxt.rdata = {30'h0, s_r.active, s_r.doneFlag};
                default: s_nxt.rdata = {31'h0, s_r.selN};
            endcase
        end
        if (regWr && regAddr == 2'h0) s_nxt.selN = ~regWdata[0];
        if (regWr && regAddr == 2'h1 && !s_r.active) begin
            s_nxt.tx = regWdata[7:0];
            s_nxt.active = 1'b1;
            s_nxt.bitCnt = BIT_FIRST;
            s_nxt.div = 8'h0;
            s_nxt.si = regWdata[7];
            s_nxt.doneFlag = 1'b0;
        end
        if (s_r.active) begin
            s_nxt.div = s_r.div + 8'h1;
            if (s_r.div == HALF_DIV) begin
                s_nxt.div = 8'h0;
                s_nxt.sck = ~s_r.sck;
                if (s_r.sck) begin
                    // Sampled just before the fall: the device answers clocks late
                    s_nxt.rx = {s_r.rx[6:0], s_r.soSync[1]};
                    s_nxt.bitCnt = s_r.bitCnt + 3'h1;
                    s_nxt.tx = {s_r.tx[6:0], 1'b0};
                    s_nxt.si = s_r.tx[6];
                    if (s_r.bitCnt == BIT_LAST) begin
                        s_nxt.active = 1'b0;
                        s_nxt.doneFlag = 1'b1;
                    end
                end
            end
        end
    end
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            s_r <= '0;
            s_r.selN <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end
    assign link.selectN = s_r.selN;
    assign link.sck = s_r.sck;
    assign link.si = s_r.si;
    assign regRdata = s_r.rdata;
endmodule

// [sim/flash_link_monitor.sv]
// Checker watching the serial link between controller and flash device
module flash_link_monitor
    import flash_buf_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic selectN,
    input wire logic sck,
    input wire logic si,
    input wire logic so,
    input wire logic soOe
);
    timeunit 1ns;
    timeprecision 1ns;
    // =====================================
    // Frame tracking
    logic sckPrev_r;
    logic [15:0] riseCnt_r;
    logic [7:0] opCode_r;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sckPrev_r <= 1'b0;
            riseCnt_r <= 16'h0000;
            opCode_r <= 8'h00;
        end else begin
            sckPrev_r <= sck;
            if (selectN) begin
                riseCnt_r <= 16'h0000;
                opCode_r <= 8'h00;
            end else if (sck && !sckPrev_r) begin
                riseCnt_r <= riseCnt_r + 16'h0001;
                // Only the first byte names the command
                if (riseCnt_r < 16'h0008) begin
                    opCode_r <= {opCode_r[6:0], si};
                end
            end
        end
    end
    // =====================================
    // Properties
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    property p_idle_clock; selectN |-> !sck; endproperty
    property p_half_period; $rose(sck) |-> sck [*4] ##1 !sck; endproperty
    property p_si_stable; (sck && $past(sck)) |-> $stable(si); endproperty
    property p_so_stable; (soOe && sck && $past(sck)) |-> $stable(so); endproperty
    property p_oe_frame; $fell(selectN) |-> !soOe [*8]; endproperty
    property p_float; selectN [*6] |-> !soOe; endproperty
    property p_dummy; (soOe && opCode_r == OP_BUF_READ) |-> riseCnt_r >= 16'h0030; endproperty
    property p_byte_edge; $rose(selectN) |-> riseCnt_r[2:0] == 3'h0; endproperty
    a_idle_clock: assert property (p_idle_clock) else $error("clock moves while idle");
    a_half_period: assert property (p_half_period) else $error("clock high time wrong");
    a_si_stable: assert property (p_si_stable) else $error("input line moved");
    a_so_stable: assert property (p_so_stable) else $error("output line moved");
    a_oe_frame: assert property (p_oe_frame) else $error("early output drive");
    a_float: assert property (p_float) else $error("output not floated");
    a_dummy: assert property (p_dummy) else $error("data before dummy byte");
    a_byte_edge: assert property (p_byte_edge) else $error("select off byte edge");
    c_frame: cover property ($rose(selectN));
    c_buf_read: cover property (soOe && opCode_r == OP_BUF_READ);
    c_status: cover property (soOe && opCode_r == OP_READ_STATUS);
endmodule

// [sim/flash_write_buffer_program_tb.sv]
// Bench joining controller and flash device back to back
module flash_write_buffer_program_tb
    import flash_buf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // =====================================
    // Signals
    logic clk_sys = 1'b0, reset_n = 1'b0, octalDdr = 1'b0, protectedTarget = 1'b0;
    logic programFail = 1'b0, regWr = 1'b0, regRd = 1'b0, oeSeen = 1'b0;
    logic [1:0] regAddr = 2'h0;
    logic [31:0] regWdata = 32'h0, regRdata, arrayAddr;
    logic busy, writeEnableLatch, programEraseErrorFlag, arrayWrite;
    logic [7:0] arrayData, rx;
    logic [31:0] seenAddr[$];
    logic [7:0] seenData[$];
    logic [7:0] rowPtr[4] = '{8'h10, 8'h11, 8'h7f, 8'hfe};
    logic [7:0] rowData[4] = '{8'h5a, 8'ha5, 8'h3c, 8'hc3};
    // Page is walked from offset zero upward
    logic [31:0] expAddr[3] = '{32'h00001200, 32'h000012fe, 32'h000012ff};
    logic [7:0] expData[3] = '{8'h33, 8'h11, 8'h22};
    int bad_count = 0, comparisons = 0, cycles = 0;
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
    $display("wrong value %s expected %0h seen %0h", n, e, g); end end
    flash_link_if link();
    flash_buf_host flash_buf_host_inst (.clk_sys(clk_sys), .reset_n(reset_n), .link(link),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata));
    flash_buf_device flash_buf_device_inst (.clk_sys(clk_sys), .reset_n(reset_n), .link(link),
        .octalDdr(octalDdr), .protectedTarget(protectedTarget), .programFail(programFail),
        .busy(busy), .writeEnableLatch(writeEnableLatch),
        .programEraseErrorFlag(programEraseErrorFlag), .arrayWrite(arrayWrite),
        .arrayAddr(arrayAddr), .arrayData(arrayData));
    flash_link_monitor flash_link_monitor_inst (.clk_sys(clk_sys), .reset_n(reset_n),
        .selectN(link.selectN), .sck(link.sck), .si(link.si), .so(link.so), .soOe(link.soOe));
    always #25 clk_sys = ~clk_sys;
    // Ceiling well above the longest expected run
    always @(posedge clk_sys) begin
        cycles++;
        if (arrayWrite === 1'b1) begin
            seenAddr.push_back(arrayAddr);
            seenData.push_back(arrayData);
        end
        if (link.soOe === 1'b1) oeSeen = 1'b1;
        if (cycles == 80000) begin
            bad_count++;
            end_sim();
        end
    end
    // =====================================
    // Tasks
    task end_sim;
        if (bad_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task regW(input logic [1:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        regAddr <= a; regWdata <= d; regWr <= 1'b1;
        @(posedge clk_sys);
        regWr <= 1'b0;
    endtask
    task regR(input logic [1:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        regAddr <= a; regRd <= 1'b1;
        @(posedge clk_sys);
        regRd <= 1'b0;
        #1 d = regRdata;
    endtask
    task xfer(input logic [7:0] b);
        logic [31:0] s;
        int n;
        regW(2'h1, {24'h0, b});
        n = 0;
        do begin regR(2'h3, s); n++; end while (s[1] !== 1'b0 && n < 200);
        regR(2'h2, s);
        rx = s[7:0];
    endtask
    task frame(input logic [7:0] q[$]);
        regW(2'h0, 32'h1);
        foreach (q[i]) xfer(q[i]);
        regW(2'h0, 32'h0);
        repeat (8) @(posedge clk_sys);
    endtask
    task bufRead(input logic [7:0] p);
        frame('{OP_BUF_READ, 8'h00, 8'h00, 8'h00, p, 8'h00, 8'h00});
    endtask
    task prog; frame('{OP_PROGRAM, 8'h00, 8'h00, 8'h12, 8'hfe, 8'h11, 8'h22, 8'h33}); endtask
    task wren; frame('{OP_WR_ENABLE}); endtask
    task stat; frame('{OP_READ_STATUS, 8'h00}); endtask
    task waitIdle;
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 5000) begin @(posedge clk_sys); n++; end
        `CHK("busy", 1'b0, busy)
    endtask
    // =====================================
    // Sequence
    initial begin
        repeat (20) @(posedge clk_sys);
        `CHK("selectN", 1'b1, link.selectN)
        `CHK("latch", 1'b0, writeEnableLatch)
        reset_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
        for (int i = 0; i < 4; i++) begin
            frame('{OP_BUF_WRITE, 8'h00, 8'h00, 8'h00, rowPtr[i], rowData[i]});
            bufRead(rowPtr[i]);
            `CHK("bufData", rowData[i], rx)
        end
        frame('{OP_BUF_WRITE, 8'h00, 8'h00, 8'h00, 8'hff, 8'he1, 8'he2});
        frame('{OP_BUF_READ, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00});
        `CHK("wrapRead", 8'he2, rx)
        bufRead(8'h10);
        `CHK("keptData", 8'h5a, rx)
        prog;
        waitIdle;
        `CHK("noLatchWrites", 0, seenAddr.size())
        wren;
        stat;
        `CHK("latchSet", 1'b1, rx[ST_LATCH])
        prog;
        stat;
        `CHK("busyBit", 1'b1, rx[ST_BUSY])
        waitIdle;
        `CHK("writeCount", 3, seenAddr.size())
        for (int j = 0; j < 3; j++) begin
            `CHK("arrayAddr", expAddr[j], seenAddr[j])
            `CHK("arrayData", expData[j], seenData[j])
        end
        stat;
        `CHK("latchDone", 1'b0, rx[ST_LATCH])
        bufRead(8'hfe);
        `CHK("sharedBuf", 8'h11, rx)
        wren;
        frame('{OP_BUF_COMMIT, 8'h00, 8'h00, 8'h34, 8'h00});
        waitIdle;
        `CHK("commitCount", 259, seenAddr.size())
        `CHK("commitFirst", 32'h00003400, seenAddr[3])
        `CHK("commitData", 8'h33, seenData[3])
        wren;
        frame('{OP_PROGRAM, 8'h00, 8'h00, 8'h12});
        waitIdle;
        `CHK("abortWrites", 259, seenAddr.size())
        `CHK("abortLatch", 1'b0, writeEnableLatch)
        protectedTarget <= 1'b1;
        wren;
        prog;
        waitIdle;
        `CHK("protWrites", 259, seenAddr.size())
        `CHK("protLatch", 1'b0, writeEnableLatch)
        protectedTarget <= 1'b0;
        programFail <= 1'b1;
        wren;
        prog;
        regW(2'h0, 32'h1);
        xfer(OP_STATUS_INT);
        xfer(8'h00);
        repeat (4) @(posedge clk_sys);
        `CHK("intBusy", 1'b1, link.so)
        waitIdle;
        repeat (4) @(posedge clk_sys);
        `CHK("intDone", 1'b0, link.so)
        regW(2'h0, 32'h0);
        repeat (8) @(posedge clk_sys);
        `CHK("errorFlag", 1'b1, programEraseErrorFlag)
        programFail <= 1'b0;
        octalDdr <= 1'b1;
        oeSeen = 1'b0;
        bufRead(8'h10);
        `CHK("octalRead", 1'b0, oeSeen)
        wren;
        frame('{OP_PROGRAM, 8'h00, 8'h00, 8'h12, 8'hfd, 8'h44, 8'h55});
        waitIdle;
        `CHK("evenCount", 264, seenAddr.size())
        `CHK("evenStart", 32'h000012fc, seenAddr[262])
        `CHK("evenData", 8'h44, seenData[262])
        octalDdr <= 1'b0;
        reset_n <= 1'b0;
        @(posedge clk_sys);
        #1 `CHK("errorReset", 1'b0, programEraseErrorFlag)
        reset_n <= 1'b1;
        end_sim();
    end
endmodule
